// ### src/frpc_pkg.sv
/*
  Constants, register map and types of the frequency reference and
  pulse counter block.
  Assumes one 100 MHz clock and an APB master with 32-bit data.
*/
// Summary of operation
// - Up to 16 step frequencies picked by inputs with function codes 12-15.
// - Step index selects table percentage, multiplied by maximum frequency.
// - Index bits with no assigned input read as zero.
// - Analog full-scale setting maps to the programmed maximum frequency.
// - Reference pulses only on the high-speed input, two-point line to max.
// - Five analog mapping curves, chosen by a curve-select field.
// - Comm source, reverse allowed: negative frequency runs reverse.
// - Inhibit plus reverse request or negative frequency: 0 Hz, no output.
// - Direction invert bit flips the rotation of a forward command.
// - Length pulses on function 27; length = pulses / pulses per meter.
// - Length-reached output once actual length exceeds set length.
// - Input with function 28 clears the accumulated length.
// - Every length pulse adds, with no direction sensing.
// - Count pulses on function 25; at set count, drive function 8, halt.
// - Designated count drives function 9 output; counting continues.
// - Counter runs whether the drive runs or stops.
// - Count value survives power loss via software save and restore.
// - Two regulator units, switched automatically or by a digital input.
package frpc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PULSE_GATE_US = 10240;
  localparam int unsigned PULSE_GATE_CYC = PULSE_GATE_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ACURVE = 8'h04;
  localparam logic [7:0] A_MAXF = 8'h08;
  localparam logic [7:0] A_DIGF = 8'h0c;
  localparam logic [7:0] A_COMMF = 8'h10;
  localparam logic [7:0] A_DIFN = 8'h14;
  localparam logic [7:0] A_DOFN = 8'h18;
  localparam logic [7:0] A_SETLEN = 8'h1c;
  localparam logic [7:0] A_PPM = 8'h20;
  localparam logic [7:0] A_ACTLEN = 8'h24;
  localparam logic [7:0] A_SETCNT = 8'h28;
  localparam logic [7:0] A_DESCNT = 8'h2c;
  localparam logic [7:0] A_COUNT = 8'h30;
  localparam logic [7:0] A_PCURVE = 8'h38;
  localparam logic [7:0] A_REGCFG = 8'h3c;
  localparam logic [7:0] A_REGREF = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_DIPOL = 8'h48;
  localparam logic [7:0] A_CURVE0 = 8'h50;
  localparam logic [7:0] A_STEP0 = 8'h80;
  localparam int unsigned NUM_CURVES = 5;
  localparam int unsigned NUM_STEPS = 16;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_INV = 4;
  localparam int unsigned CTRL_RINH = 5;
  localparam int unsigned CTRL_AUTO = 6;
  localparam int unsigned FN_W = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAXF_RST = 16'h1388;
  localparam logic [15:0] PPM_RST = 16'h0001;
  localparam logic [15:0] SETCNT_RST = 16'h03e8;
  localparam logic [31:0] CURVE_RST = 32'h0400_0000;
  localparam logic [31:0] REGCFG_RST = 32'h0080_1010;
  localparam logic [12:0] FULL_PCT = 13'h0400;
  localparam logic [12:0] PULSE_FULL = 13'h0400;
  // ----------------------------------------------------------------
  // Function and source codes
  // ----------------------------------------------------------------
  localparam logic [5:0] FN_STEP0 = 6'h0c;
  localparam logic [5:0] FN_STEP3 = 6'h0f;
  localparam logic [5:0] FN_COUNT = 6'h19;
  localparam logic [5:0] FN_LEN = 6'h1b;
  localparam logic [5:0] FN_LENRST = 6'h1c;
  localparam logic [5:0] FN_REGSW = 6'h2b;
  localparam logic [5:0] FO_SETCNT = 6'h08;
  localparam logic [5:0] FO_DESCNT = 6'h09;
  localparam logic [5:0] FO_LEN = 6'h14;
  typedef enum logic [3:0] {
    SRC_DIG0, SRC_DIG1, SRC_AI1, SRC_AI2, SRC_POT,
    SRC_PULSE, SRC_STEP, SRC_PLC, SRC_REG, SRC_COMM
  } frpc_src_t;
  typedef struct packed {
    logic [15:0] freq;
    logic reverse;
    logic enable;
  } frpc_drive_t;
endpackage

// ### src/frpc_top.sv
/*
  Frequency reference selection, direction handling, fixed-length
  measurement and count comparator, with an APB register slave.
  Assumes terminal inputs already synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module frpc_top #(
  parameter int unsigned PULSE_GATE = frpc_pkg::PULSE_GATE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] diTerm,
  input wire logic fwdRun,
  input wire logic revRun,
  input wire logic [11:0] ai1Level,
  input wire logic [11:0] ai2Level,
  input wire logic [11:0] potLevel,
  input wire logic [11:0] regFeedback,
  output frpc_pkg::frpc_drive_t drive,
  output logic [2:0] doTerm
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, acurve_reg, difn_reg, dofn_reg;
  logic [31:0] pcurve_reg, regcfg_reg;
  logic [15:0] maxf_reg, digf_reg, commf_reg, setlen_reg, ppm_reg;
  logic [15:0] setcnt_reg, descnt_reg, count_reg, actlen_reg;
  logic [15:0] lensub_reg;
  logic [11:0] regref_reg;
  logic [4:0] dipol_reg, di_reg, diPrev_reg;
  logic [31:0] curve_mem [frpc_pkg::NUM_CURVES];
  logic [11:0] step_mem [frpc_pkg::NUM_STEPS];
  logic [31:0] gate_reg;
  logic [12:0] pacc_reg, pmeas_reg;
  logic lenHit_reg, setHit_reg, desHit_reg, regUnit_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  frpc_pkg::frpc_drive_t drive_reg;
  logic [2:0] do_reg;
  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state, so that read data leaves a flip-flop
  logic access, wrEn, hit;
  logic [31:0] readData;
  assign access = psel && penable && !pready_reg;
  assign wrEn = psel && penable && pready_reg && pwrite && !pslverr_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access;
      if (access)
      begin
        prdata_reg <= pwrite ? 32'h0000_0000 : readData;
        pslverr_reg <= !hit;
      end
      else
      begin
        pslverr_reg <= 1'b0;
      end
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= 32'h0000_0000;
      acurve_reg <= 32'h0000_0000;
      maxf_reg <= frpc_pkg::MAXF_RST;
      digf_reg <= 16'h0000;
      commf_reg <= 16'h0000;
      difn_reg <= 32'h0000_0000;
      dofn_reg <= 32'h0000_0000;
      setlen_reg <= 16'h0000;
      ppm_reg <= frpc_pkg::PPM_RST;
      setcnt_reg <= frpc_pkg::SETCNT_RST;
      descnt_reg <= 16'h0000;
      pcurve_reg <= frpc_pkg::CURVE_RST;
      regcfg_reg <= frpc_pkg::REGCFG_RST;
      regref_reg <= 12'h000;
      dipol_reg <= 5'h00;
    end
    else if (wrEn)
    begin
      case (paddr)
        frpc_pkg::A_CTRL: ctrl_reg <= {25'h0, pwdata[6:0]};
        frpc_pkg::A_ACURVE: acurve_reg <= {21'h0, pwdata[10:0]};
        frpc_pkg::A_MAXF: maxf_reg <= pwdata[15:0];
        frpc_pkg::A_DIGF: digf_reg <= pwdata[15:0];
        frpc_pkg::A_COMMF: commf_reg <= pwdata[15:0];
        frpc_pkg::A_DIFN: difn_reg <= {2'h0, pwdata[29:0]};
        frpc_pkg::A_DOFN: dofn_reg <= {14'h0, pwdata[17:0]};
        frpc_pkg::A_SETLEN: setlen_reg <= pwdata[15:0];
        frpc_pkg::A_PPM: ppm_reg <= pwdata[15:0];
        frpc_pkg::A_SETCNT: setcnt_reg <= pwdata[15:0];
        frpc_pkg::A_DESCNT: descnt_reg <= pwdata[15:0];
        frpc_pkg::A_PCURVE: pcurve_reg <= pwdata;
        frpc_pkg::A_REGCFG: regcfg_reg <= pwdata;
        frpc_pkg::A_REGREF: regref_reg <= pwdata[11:0];
        frpc_pkg::A_DIPOL: dipol_reg <= pwdata[4:0];
        default: ;
      endcase
    end
  end
  // Curves and step table; no reset keeps them plain RAM
  // Curve window crosses a 32-byte boundary, so decode by offset
  logic curveSel;
  logic [7:0] curveOff;
  assign curveOff = paddr - frpc_pkg::A_CURVE0;
  assign curveSel = paddr >= frpc_pkg::A_CURVE0
    && curveOff[7:2] < 6'(frpc_pkg::NUM_CURVES);
  always_ff @(posedge sys_clk)
  begin
    if (wrEn && curveSel)
    begin
      curve_mem[curveOff[4:2]] <= pwdata;
    end
    if (wrEn && paddr[7:6] == 2'b10)
    begin
      step_mem[paddr[5:2]] <= pwdata[11:0];
    end
  end
  // ----------------------------------------------------------------
  // Terminal decode
  // ----------------------------------------------------------------
  logic [3:0] stepIdx;
  logic [5:0] fn;
  logic cntPulse, lenPulse, lenClr, regSw;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      di_reg <= 5'h00;
      diPrev_reg <= 5'h00;
    end
    else
    begin
      di_reg <= diTerm ^ dipol_reg;
      diPrev_reg <= di_reg;
    end
  end
  always_comb
  begin
    fn = 6'h00;
    stepIdx = 4'h0;
    cntPulse = 1'b0;
    lenClr = 1'b0;
    regSw = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      fn = difn_reg[i*frpc_pkg::FN_W +: frpc_pkg::FN_W];
      if (fn >= frpc_pkg::FN_STEP0 && fn <= frpc_pkg::FN_STEP3)
      begin
        stepIdx[2'(fn - frpc_pkg::FN_STEP0)] = di_reg[i];
      end
      if (fn == frpc_pkg::FN_COUNT && di_reg[i] && !diPrev_reg[i])
      begin
        cntPulse = 1'b1;
      end
      if (fn == frpc_pkg::FN_LENRST && di_reg[i])
      begin
        lenClr = 1'b1;
      end
      if (fn == frpc_pkg::FN_REGSW && di_reg[i])
      begin
        regSw = 1'b1;
      end
    end
  end
  // Length pulses only on the high-speed terminal
  assign lenPulse = difn_reg[29:24] == frpc_pkg::FN_LEN
    && di_reg[4] && !diPrev_reg[4];
  // ----------------------------------------------------------------
  // Length measurement
  // ----------------------------------------------------------------
  // Division by repeated subtraction, one pulse at a time
  logic [15:0] ppmEff;
  assign ppmEff = (ppm_reg == 16'h0000) ? 16'h0001 : ppm_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lensub_reg <= 16'h0000;
      actlen_reg <= 16'h0000;
      lenHit_reg <= 1'b0;
    end
    else
    begin
      if (lenClr)
      begin
        lensub_reg <= 16'h0000;
        actlen_reg <= 16'h0000;
      end
      else if (lenPulse)
      begin
        if (lensub_reg + 16'h0001 >= ppmEff)
        begin
          lensub_reg <= 16'h0000;
          if (actlen_reg != 16'hffff)
          begin
            actlen_reg <= actlen_reg + 16'h0001;
          end
        end
        else
        begin
          lensub_reg <= lensub_reg + 16'h0001;
        end
      end
      lenHit_reg <= actlen_reg > setlen_reg;
    end
  end
  // ----------------------------------------------------------------
  // Count comparator
  // ----------------------------------------------------------------
  // Runs regardless of drive state; software saves and restores it
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= 16'h0000;
      setHit_reg <= 1'b0;
      desHit_reg <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == frpc_pkg::A_COUNT)
      begin
        count_reg <= pwdata[15:0];
      end
      else if (cntPulse && count_reg < setcnt_reg)
      begin
        count_reg <= count_reg + 16'h0001;
      end
      setHit_reg <= count_reg >= setcnt_reg;
      desHit_reg <= count_reg >= descnt_reg;
    end
  end
  // ----------------------------------------------------------------
  // Pulse frequency measurement
  // ----------------------------------------------------------------
  // The gate is sized so that full-scale rate gives 1024 pulses
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gate_reg <= 32'h0000_0000;
      pacc_reg <= 13'h0000;
      pmeas_reg <= 13'h0000;
    end
    else if (gate_reg >= 32'(PULSE_GATE - 1))
    begin
      gate_reg <= 32'h0000_0000;
      pacc_reg <= 13'h0000;
      pmeas_reg <= pacc_reg;
    end
    else
    begin
      gate_reg <= gate_reg + 32'h0000_0001;
      if (di_reg[4] && !diPrev_reg[4] && pacc_reg < frpc_pkg::PULSE_FULL)
      begin
        pacc_reg <= pacc_reg + 13'h0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // Source mapping
  // ----------------------------------------------------------------
  // Two-point line, 4096 input units span the curve, Q10 result
  function automatic logic signed [12:0] mapLine(
    input logic [12:0] x,
    input logic [31:0] c
  );
    logic signed [13:0] y0, y1, d;
    logic signed [27:0] p;
    y0 = 14'(signed'(c[11:0]));
    y1 = 14'(signed'(c[27:16]));
    d = y1 - y0;
    p = d * signed'({1'b0, x});
    return 13'(y0 + 14'(p >>> 12));
  endfunction
  logic signed [12:0] pctAi1, pctAi2, pctPot, pctPulse, pctSel;
  logic signed [12:0] pctReg, regErr;
  logic signed [21:0] regProd;
  logic signed [30:0] freqProd;
  logic signed [17:0] freqSig;
  logic [17:0] freqMag;
  always_comb
  begin
    pctAi1 = mapLine({1'b0, ai1Level}, curve_mem[acurve_reg[2:0]]);
    pctAi2 = mapLine({1'b0, ai2Level}, curve_mem[acurve_reg[6:4]]);
    pctPot = mapLine({1'b0, potLevel}, curve_mem[acurve_reg[10:8]]);
    pctPulse = mapLine(13'(pmeas_reg << 2), pcurve_reg);
    regErr = signed'({1'b0, regref_reg}) - signed'({1'b0, regFeedback});
    regProd = regErr * signed'({1'b0,
      regUnit_reg ? regcfg_reg[15:8] : regcfg_reg[7:0]});
    pctReg = 13'(signed'({1'b0, regref_reg}) + 13'(regProd >>> 4));
    if (pctReg < 0)
    begin
      pctReg = 13'h0000;
    end
    else if (pctReg > signed'(frpc_pkg::FULL_PCT))
    begin
      pctReg = frpc_pkg::FULL_PCT;
    end
    case (frpc_pkg::frpc_src_t'(ctrl_reg[3:0]))
      frpc_pkg::SRC_AI1: pctSel = pctAi1;
      frpc_pkg::SRC_AI2: pctSel = pctAi2;
      frpc_pkg::SRC_POT: pctSel = pctPot;
      frpc_pkg::SRC_PULSE: pctSel = pctPulse;
      frpc_pkg::SRC_STEP: pctSel = 13'(step_mem[stepIdx]);
      frpc_pkg::SRC_REG: pctSel = pctReg;
      default: pctSel = 13'h0000;
    endcase
    freqProd = pctSel * signed'({1'b0, maxf_reg});
    case (frpc_pkg::frpc_src_t'(ctrl_reg[3:0]))
      frpc_pkg::SRC_DIG0, frpc_pkg::SRC_DIG1:
        freqSig = 18'(signed'(digf_reg));
      frpc_pkg::SRC_COMM: freqSig = 18'(signed'(commf_reg));
      frpc_pkg::SRC_PLC: freqSig = 18'h00000;
      default: freqSig = 18'(freqProd >>> 10);
    endcase
    freqMag = freqSig < 0 ? 18'(-freqSig) : 18'(freqSig);
    if (freqMag > {2'b00, maxf_reg})
    begin
      freqMag = {2'b00, maxf_reg};
    end
  end
  // ----------------------------------------------------------------
  // Regulator unit selection
  // ----------------------------------------------------------------
  // Automatic mode takes unit 1 for large errors, unit 0 near target
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regUnit_reg <= 1'b0;
    end
    else if (ctrl_reg[frpc_pkg::CTRL_AUTO])
    begin
      regUnit_reg <= (regErr < 0 ? -regErr : regErr)
        > signed'({1'b0, regcfg_reg[27:16]});
    end
    else
    begin
      regUnit_reg <= regSw;
    end
  end
  // ----------------------------------------------------------------
  // Direction and drive command
  // ----------------------------------------------------------------
  logic cmdRev, runCmd, negRef;
  assign runCmd = fwdRun ^ revRun;
  assign cmdRev = revRun && !fwdRun;
  assign negRef = freqSig < 0;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_reg <= '0;
    end
    else if (!runCmd)
    begin
      drive_reg <= '0;
    end
    else if (ctrl_reg[frpc_pkg::CTRL_RINH] && (cmdRev || negRef))
    begin
      drive_reg <= '0;
    end
    else
    begin
      drive_reg.freq <= freqMag[15:0];
      drive_reg.reverse <= cmdRev ^ negRef
        ^ ctrl_reg[frpc_pkg::CTRL_INV];
      drive_reg.enable <= 1'b1;
    end
  end
  assign drive = drive_reg;
  // ----------------------------------------------------------------
  // Digital outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      do_reg <= 3'h0;
    end
    else
    begin
      for (int j = 0; j < 3; j++)
      begin
        case (dofn_reg[j*frpc_pkg::FN_W +: frpc_pkg::FN_W])
          frpc_pkg::FO_SETCNT: do_reg[j] <= setHit_reg;
          frpc_pkg::FO_DESCNT: do_reg[j] <= desHit_reg;
          frpc_pkg::FO_LEN: do_reg[j] <= lenHit_reg;
          default: do_reg[j] <= 1'b0;
        endcase
      end
    end
  end
  assign doTerm = do_reg;
  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    hit = 1'b1;
    readData = 32'h0000_0000;
    case (paddr)
      frpc_pkg::A_CTRL: readData = ctrl_reg;
      frpc_pkg::A_ACURVE: readData = acurve_reg;
      frpc_pkg::A_MAXF: readData = {16'h0, maxf_reg};
      frpc_pkg::A_DIGF: readData = {16'h0, digf_reg};
      frpc_pkg::A_COMMF: readData = {16'h0, commf_reg};
      frpc_pkg::A_DIFN: readData = difn_reg;
      frpc_pkg::A_DOFN: readData = dofn_reg;
      frpc_pkg::A_SETLEN: readData = {16'h0, setlen_reg};
      frpc_pkg::A_PPM: readData = {16'h0, ppm_reg};
      frpc_pkg::A_ACTLEN: readData = {16'h0, actlen_reg};
      frpc_pkg::A_SETCNT: readData = {16'h0, setcnt_reg};
      frpc_pkg::A_DESCNT: readData = {16'h0, descnt_reg};
      frpc_pkg::A_COUNT: readData = {16'h0, count_reg};
      frpc_pkg::A_PCURVE: readData = pcurve_reg;
      frpc_pkg::A_REGCFG: readData = regcfg_reg;
      frpc_pkg::A_REGREF: readData = {20'h0, regref_reg};
      frpc_pkg::A_DIPOL: readData = {27'h0, dipol_reg};
      frpc_pkg::A_STATUS: readData = {6'h0, stepIdx, regUnit_reg,
        desHit_reg, setHit_reg, lenHit_reg, drive_reg};
      default:
      begin
        if (paddr[7:6] == 2'b10)
        begin
          readData = {20'h0, step_mem[paddr[5:2]]};
        end
        else if (curveSel)
        begin
          readData = curve_mem[curveOff[4:2]];
        end
        else
        begin
          hit = 1'b0;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ### verification/frpc_asserts.sv
/*
  Checker for frpc_top: APB answer timing, stop level, output calm.
  Assumes binding to frpc_top with its single clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module frpc_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] diTerm,
  input wire logic fwdRun,
  input wire logic revRun,
  input wire frpc_pkg::frpc_drive_t drive,
  input wire logic [2:0] doTerm
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_late_a: assert property (pready |->
    access_s and $past(psel && penable))
    else $error("pready outside second access cycle");
  sel_quiet_a: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without select");
  err_slot_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  hole_err_a: assert property (pready && paddr == 8'h34
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  stop_idle_a: assert property ((fwdRun == revRun) [*3] |-> !drive.enable)
    else $error("drive enabled without run command");
  // Pulse outputs settle within four edges, so six calm cycles suffice
  out_calm_a: assert property (($stable(diTerm) && !psel) [*6]
    |-> $stable(doTerm))
    else $error("outputs moved without cause");
endmodule
bind frpc_top frpc_asserts u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .diTerm(diTerm), .fwdRun(fwdRun),
  .revRun(revRun), .drive(drive), .doTerm(doTerm));
`default_nettype wire

// ### verification/frpc_term_model.sv
/*
  Terminal model: switch levels and pulse bursts on the digital inputs.
  Assumes the bench sets level and burst right after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module frpc_term_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [4:0] level,
  input wire logic [4:0] burst,
  output logic [4:0] diTerm
);
  // Burst bits toggle: one cycle high, one low, the fastest legal pulse
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      diTerm <= 5'h00;
    else
      diTerm <= (~diTerm & burst) | (level & ~burst);
endmodule
`default_nettype wire

// ### verification/frpc_top_test.sv
/*
  Self-checking bench for frpc_top over APB and terminal stimulus.
  Assumes the checker and terminal model are compiled beforehand.
*/
`timescale 1ns/1ns
`default_nettype none
module frpc_top_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fwdRun = 1'b0;
  logic revRun = 1'b0;
  logic [11:0] ai1Level = 12'h000;
  logic [4:0] level = 5'h00;
  logic [4:0] burst = 5'h00;
  logic [4:0] diTerm;
  logic [2:0] doTerm;
  frpc_pkg::frpc_drive_t drive;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int num_checks = 0;
  initial forever #5 sys_clk = ~sys_clk;
  // Short gate keeps pulse measurement quick
  frpc_top #(.PULSE_GATE(64)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .diTerm(diTerm), .fwdRun(fwdRun), .revRun(revRun),
    .ai1Level(ai1Level), .ai2Level(12'h000), .potLevel(12'h000),
    .regFeedback(12'h000), .drive(drive), .doTerm(doTerm));
  frpc_term_model u_term (.sys_clk(sys_clk), .reset_n(reset_n),
    .level(level), .burst(burst), .diTerm(diTerm));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 20)
    begin
      err_total++;
      $display("[ERR] pready exp 1 got 0");
      end_sim;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic pulses(input logic [4:0] m, input int n);
    burst <= m;
    repeat (2 * n) @(posedge sys_clk);
    burst <= 5'h00;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic dcase(input logic [31:0] c, input logic [31:0] s,
    input logic fw, input logic rv, input logic [15:0] f,
    input logic r, input logic e);
    apb(1'b1, 8'h10, s);
    apb(1'b1, 8'h00, c);
    fwdRun <= fw;
    revRun <= rv;
    repeat (6) @(posedge sys_clk);
    chk("drive", {14'h0, f, r, e}, {14'h0, drive});
  endtask
  task automatic t_regs;
    rc(8'h08, 32'h0000_1388);
    rc(8'h28, 32'h0000_03e8);
    rc(8'h20, 32'h0000_0001);
    apb(1'b0, 8'h34, 32'h0);
    chk("hole error", 32'h1, {31'h0, er});
    chk("hole data", 32'h0, rd);
    $display("t_regs done");
  endtask
  task automatic t_step;
    // Terminal 3 carries function 13, so it sets index bit 1
    apb(1'b1, 8'h14, 32'h1b34_0719);
    apb(1'b1, 8'h18, 32'h0001_4248);
    apb(1'b1, 8'h88, 32'h0000_0200);
    apb(1'b1, 8'h00, 32'h0000_0006);
    level <= 5'h08;
    fwdRun <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("drive", {14'h0, 16'd2500, 2'b01},
      {14'h0, drive});
    $display("t_step done");
  endtask
  task automatic t_dir;
    dcase(32'h09, 32'hfc18, 1'b1, 1'b0, 16'd1000, 1'b1, 1'b1);
    dcase(32'h29, 32'hfc18, 1'b1, 1'b0, 16'd0, 1'b0, 1'b0);
    dcase(32'h29, 32'h03e8, 1'b0, 1'b1, 16'd0, 1'b0, 1'b0);
    dcase(32'h19, 32'h03e8, 1'b1, 1'b0, 16'd1000, 1'b1, 1'b1);
    $display("t_dir done");
  endtask
  task automatic t_count;
    fwdRun <= 1'b0;
    apb(1'b1, 8'h28, 32'h3);
    apb(1'b1, 8'h2c, 32'h2);
    apb(1'b1, 8'h30, 32'h0);
    pulses(5'h01, 2);
    chk("count outputs", 32'h2, {29'h0, doTerm});
    pulses(5'h01, 3);
    chk("count outputs", 32'h3, {29'h0, doTerm});
    rc(8'h30, 32'h3);
    apb(1'b1, 8'h30, 32'h1);
    rc(8'h30, 32'h1);
    $display("t_count done");
  endtask
  task automatic t_len;
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b1, 8'h1c, 32'h1);
    revRun <= 1'b1;
    pulses(5'h10, 4);
    rc(8'h24, 32'h2);
    chk("length output", 32'h4, {29'h0, doTerm});
    apb(1'b1, 8'h1c, 32'h2);
    repeat (4) @(posedge sys_clk);
    chk("length output", 32'h0, {29'h0, doTerm});
    level <= 5'h0a;
    repeat (8) @(posedge sys_clk);
    rc(8'h24, 32'h0);
    level <= 5'h08;
    $display("t_len done");
  endtask
  task automatic t_src;
    // Regulator: 256 + (256 * 16 >> 4) = 512, half of maximum
    apb(1'b1, 8'h40, 32'h0000_0100);
    dcase(32'h08, 32'h0, 1'b1, 1'b0, 16'd2500, 1'b0, 1'b1);
    // Fifth curve, zero to full scale, on analog input 1
    apb(1'b1, 8'h60, 32'h0400_0000);
    chk("curve error", 32'h0, {31'h0, er});
    apb(1'b1, 8'h04, 32'h0000_0004);
    ai1Level <= 12'h800;
    dcase(32'h02, 32'h0, 1'b1, 1'b0, 16'd2500, 1'b0, 1'b1);
    $display("t_src done");
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_step;
    t_dir;
    t_count;
    t_len;
    t_src;
    end_sim;
  end
endmodule
`default_nettype wire
